// file: core/t8c_timer.sv
// t8c_timer: 8-bit timer top, counter, flags, compare channels, pin mux
// assumes: AHB-Lite master, tick from an outside prescaler, port regs outside
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// [RULE_01] counter write blocks next tick's compare matches
// [RULE_02] software avoids writing count equal compare
// [RULE_03] software sets output state before pin direction
// [RULE_04] output states kept across mode changes
// [RULE_05] output action field used unbuffered
// [RULE_06] reset clears output states to zero
// [RULE_07] nonzero action overrides port output value
// [RULE_08] pin driven only when direction is output
// [RULE_09] override depends only on action field
// [RULE_10] action zero leaves output state unchanged
// [RULE_11] new action governs next compare match
// [RULE_12] force strobe applies action in non-PWM modes
// [RULE_13] mode sets counting, action sets output only
// [RULE_14] mode zero counts up, wraps ff to 00
// [RULE_15] overflow flag set when counter becomes zero
// [RULE_16] overflow flag cleared when interrupt serviced
// [RULE_17] mode two clears counter on compare A
// [RULE_18] compare A unbuffered; missed match wraps first
// [RULE_19] compare flag A set at top in clear-on-match
// [RULE_20] action one toggles output on each match
// [RULE_21] clear-on-match overflow set on max to zero
// [RULE_22] forced compare sets no flag, keeps counter
// [RULE_23] equality sets compare flag on next tick
// [RULE_24] compare flags clear by write one or service
// [RULE_25] bottom is 00, max is ff
// [RULE_26] timer clock is a one-cycle count enable
module t8c_timer import t8c_pkg::*; (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        tick,
  input  wire logic        ovf_ack,
  input  wire logic        cmpa_ack,
  input  wire logic        cmpb_ack,
  input  wire logic [1:0]  port_out,
  input  wire logic [1:0]  port_dir,
  output logic [1:0]       pin_out,
  output logic [1:0]       pin_oe,
  output logic             overflow_flag,
  output logic             compare_flag_a,
  output logic             compare_flag_b
);
  // ==========================================================
  // declarations
  t8c_reg_if   regs ();            // bus slave to core strobes
  logic [2:0]  mode_r;             // waveform_mode_select
  logic [1:0]  act_r [2];          // compare_output_action per channel
  logic [7:0]  cmp_r [2];          // compare_value per channel
  logic [7:0]  counter_value_r;    // counter_value
  logic [7:0]  counter_value_nxt;  // next counter value
  logic        block_r;            // matches blocked until next tick
  logic        ovf_r;              // overflow_flag
  logic [1:0]  cflag_r;            // compare flags a and b
  logic [1:0]  ostate;             // compare_output_state per channel
  logic [1:0]  cmp_match;          // blocked-qualified match at tick
  logic [1:0]  force_stb;          // force strobe per channel
  logic [1:0]  cflag_clr;          // compare flag clear per channel
  logic [1:0]  cflag_ack;          // service acks per channel
  logic        wr_ctrl;            // write decodes
  logic        wr_force;
  logic        wr_cnt;
  logic        wr_cmpa;
  logic        wr_cmpb;
  logic        wr_flg;
  logic        nonpwm;             // even modes carry set/clear/toggle
  logic        clr_match;          // clear-on-match mode
  logic        ovf_set;            // counter passes from max to zero
  logic        ovf_clr;            // overflow clear by service or write
  logic        size_unused;        // hsize not checked, word only

  assign size_unused = |hsize;

  // ==========================================================
  // bus slave
  t8c_ahb_slv u_slv (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regs      (regs.slv)
  );

  // ==========================================================
  // write decode, unmapped offsets are ignored
  assign wr_ctrl  = regs.wr_stb & (regs.addr == ADDR_CTRL);
  assign wr_force = regs.wr_stb & (regs.addr == ADDR_FORCE);
  assign wr_cnt   = regs.wr_stb & (regs.addr == ADDR_COUNT);
  assign wr_cmpa  = regs.wr_stb & (regs.addr == ADDR_CMPA);
  assign wr_cmpb  = regs.wr_stb & (regs.addr == ADDR_CMPB);
  assign wr_flg   = regs.wr_stb & (regs.addr == ADDR_FLAGS);

  // odd modes are the PWM modes; they are not built and count freely
  assign nonpwm    = !mode_r[0];
  assign clr_match = (mode_r == MODE_CLRM);

  // ==========================================================
  // control register: mode and output actions, no shadow copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r   <= CTRL_RST[CTRL_MODE_LSB +: 3];
      act_r[0] <= CTRL_RST[CTRL_ACTA_LSB +: 2];
      act_r[1] <= CTRL_RST[CTRL_ACTB_LSB +: 2];
    end else if (wr_ctrl) begin
      mode_r   <= regs.wdata[CTRL_MODE_LSB +: 3];
      act_r[0] <= regs.wdata[CTRL_ACTA_LSB +: 2]; // see [RULE_05]
      act_r[1] <= regs.wdata[CTRL_ACTB_LSB +: 2];
    end
  end

  // compare values written straight through, no double buffer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_r[0] <= CMP_RST;
      cmp_r[1] <= CMP_RST;
    end else begin
      if (wr_cmpa) begin
        cmp_r[0] <= regs.wdata; // see [RULE_18]
      end
      if (wr_cmpb) begin
        cmp_r[1] <= regs.wdata;
      end
    end
  end

  // ==========================================================
  // counter: a bus write beats clear and count
  always_comb begin
    counter_value_nxt = counter_value_r;
    if (wr_cnt) begin
      counter_value_nxt = regs.wdata;
    end else if (tick) begin // see [RULE_26]
      if (clr_match && cmp_match[0]) begin
        counter_value_nxt = BOTTOM; // see [RULE_17]
      end else begin
        // wraps max to bottom on its own, see [RULE_14] see [RULE_25]
        counter_value_nxt = counter_value_r + 8'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_value_r <= COUNT_RST;
    end else begin
      counter_value_r <= counter_value_nxt; // see [RULE_13]
    end
  end

  // a counter write arms the block, the next tick spends it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      block_r <= 1'b0;
    end else if (wr_cnt) begin
      block_r <= 1'b1; // see [RULE_01]
    end else if (tick) begin
      block_r <= 1'b0;
    end
  end

  // ==========================================================
  // overflow flag, set wins over any clear
  assign ovf_set = tick & !wr_cnt & (counter_value_r == MAX); // see [RULE_21]
  assign ovf_clr = ovf_ack | (wr_flg & regs.wdata[FLG_OVF]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_r <= 1'b0;
    end else if (ovf_set) begin
      ovf_r <= 1'b1; // see [RULE_15]
    end else if (ovf_clr) begin
      ovf_r <= 1'b0; // see [RULE_16]
    end
  end

  // ==========================================================
  // per-channel compare units, flags and pin override
  assign force_stb[0] = wr_force & regs.wdata[0];
  assign force_stb[1] = wr_force & regs.wdata[1];
  assign cflag_ack    = {cmpb_ack, cmpa_ack};
  assign cflag_clr[0] = cflag_ack[0] | (wr_flg & regs.wdata[FLG_CMPA]);
  assign cflag_clr[1] = cflag_ack[1] | (wr_flg & regs.wdata[FLG_CMPB]);

  for (genvar i = 0; i < 2; i++) begin : g_chan
    t8c_cmp_chan u_chan (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .tick      (tick),
      .blocked   (block_r),
      .nonpwm    (nonpwm),
      .count     (counter_value_r),
      .compare   (cmp_r[i]),
      .action    (act_r[i]),
      .force_stb (force_stb[i]), // see [RULE_12]
      .match     (cmp_match[i]),
      .state_r   (ostate[i])
    );

    // a forced compare never reaches the flag, see [RULE_22]
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cflag_r[i] <= 1'b0;
      end else if (cmp_match[i]) begin
        cflag_r[i] <= 1'b1; // see [RULE_23] see [RULE_19]
      end else if (cflag_clr[i]) begin
        cflag_r[i] <= 1'b0; // see [RULE_24]
      end
    end

    // override chosen by the action field only, whatever the mode
    assign pin_out[i] = (|act_r[i]) ? ostate[i] : port_out[i]; // see [RULE_09] see [RULE_07]
    assign pin_oe[i]  = port_dir[i];                          // see [RULE_08]
  end

  // ==========================================================
  // read mux, unmapped and write-only offsets read zero
  always_comb begin
    case (regs.addr)
      ADDR_CTRL:   regs.rdata = {act_r[1], act_r[0], 1'b0, mode_r};
      ADDR_COUNT:  regs.rdata = counter_value_r;
      ADDR_CMPA:   regs.rdata = cmp_r[0];
      ADDR_CMPB:   regs.rdata = cmp_r[1];
      ADDR_FLAGS:  regs.rdata = {5'h00, cflag_r, ovf_r};
      ADDR_STATUS: regs.rdata = {6'h00, ostate};
      default:     regs.rdata = 8'h00;
    endcase
  end

  assign overflow_flag  = ovf_r;
  assign compare_flag_a = cflag_r[0];
  assign compare_flag_b = cflag_r[1];

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_block;
    (block_r && tick && !wr_force) |=>
      (cflag_r == ($past(cflag_r) & ~$past(cflag_clr)) && ostate == $past(ostate));
  endproperty
  a_block: assert property (p_block) // see [RULE_01]
    else $error("compare match not blocked after counter write");

  property p_block_arm;
    wr_cnt |=> (block_r && counter_value_r == $past(regs.wdata));
  endproperty
  a_block_arm: assert property (p_block_arm) // see [RULE_01]
    else $error("counter write did not load and arm block");

  property p_count_up;
    (tick && !wr_cnt && !clr_match) |=>
      (counter_value_r == $past(counter_value_r) + 8'h01);
  endproperty
  a_count_up: assert property (p_count_up) // see [RULE_14]
    else $error("counter did not step by one");

  property p_ovf_set;
    (tick && !wr_cnt && counter_value_r == MAX) |=>
      (ovf_r && counter_value_r == BOTTOM);
  endproperty
  a_ovf_set: assert property (p_ovf_set) // see [RULE_15]
    else $error("overflow not flagged on wrap");

  property p_ovf_hold;
    (ovf_r && !ovf_clr) |=> ovf_r;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) // see [RULE_15]
    else $error("overflow flag dropped without clear");

  property p_ovf_ack;
    (ovf_ack && !ovf_set) |=> !ovf_r;
  endproperty
  a_ovf_ack: assert property (p_ovf_ack) // see [RULE_16]
    else $error("service did not clear overflow flag");

  property p_clr_match;
    (clr_match && tick && !wr_cnt && !block_r && counter_value_r == cmp_r[0]) |=>
      (counter_value_r == BOTTOM && cflag_r[0]);
  endproperty
  a_clr_match: assert property (p_clr_match) // see [RULE_17]
    else $error("clear-on-match did not clear and flag");

  property p_w1c;
    (wr_flg && regs.wdata[FLG_CMPA] && !cmp_match[0]) |=> !cflag_r[0];
  endproperty
  a_w1c: assert property (p_w1c) // see [RULE_24]
    else $error("write one did not clear compare flag a");

  property p_force_noflag;
    (force_stb[0] && !tick && !cflag_r[0]) |=>
      (!cflag_r[0] && $stable(counter_value_r));
  endproperty
  a_force_noflag: assert property (p_force_noflag) // see [RULE_22]
    else $error("forced compare touched flag");

  property p_override;
    (act_r[0] != ACT_NONE) |-> (pin_out[0] == ostate[0] && pin_oe == port_dir);
  endproperty
  a_override: assert property (p_override) // see [RULE_07]
    else $error("pin not taken over by compare state");

  property p_mode_keep;
    (wr_ctrl && cmp_match == 2'b00) |=> (ostate == $past(ostate));
  endproperty
  a_mode_keep: assert property (p_mode_keep) // see [RULE_04]
    else $error("output state changed on control write");

  // channel B flag follows its own match one edge later
  property p_cmp_flag_b;
    cmp_match[1] |=> cflag_r[1];
  endproperty
  a_cmp_flag_b: assert property (p_cmp_flag_b) // see [RULE_23]
    else $error("compare flag b not set after match");

  // the force strobe is dead in the odd, pwm modes
  property p_pwm_noforce;
    (wr_force && !nonpwm) |=> (ostate == $past(ostate));
  endproperty
  a_pwm_noforce: assert property (p_pwm_noforce) // see [RULE_12]
    else $error("force strobe moved state in a pwm mode");

  // cover points of the main scenarios
  c_wrap:   cover property (tick && counter_value_r == MAX ##1 ovf_r);
  c_clrm:   cover property (clr_match && cmp_match[0] ##1 counter_value_r == BOTTOM);
  c_force:  cover property (force_stb[0] && nonpwm && act_r[0] == ACT_SET);
  c_block:  cover property (block_r && tick && counter_value_r == cmp_r[0]);
endmodule // t8c_timer

// file: core/t8c_pkg.sv
// t8c_pkg: shared constants of the 8-bit timer compare block
// assumes: word-aligned register offsets on a 32-bit AHB-Lite slave
package t8c_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00; // mode and output actions
  localparam logic [7:0] ADDR_FORCE  = 8'h04; // force strobes, reads zero
  localparam logic [7:0] ADDR_COUNT  = 8'h08; // counter_value
  localparam logic [7:0] ADDR_CMPA   = 8'h0c; // compare_value_a
  localparam logic [7:0] ADDR_CMPB   = 8'h10; // compare_value_b
  localparam logic [7:0] ADDR_FLAGS  = 8'h14; // flags, write one to clear
  localparam logic [7:0] ADDR_STATUS = 8'h18; // compare output states
  // ==========================================================
  // field positions
  localparam int CTRL_MODE_LSB = 0;  // waveform_mode_select [2:0]
  localparam int CTRL_ACTA_LSB = 4;  // compare_output_action_a [5:4]
  localparam int CTRL_ACTB_LSB = 6;  // compare_output_action_b [7:6]
  localparam int FLG_OVF       = 0;  // overflow_flag
  localparam int FLG_CMPA      = 1;  // compare_flag_a
  localparam int FLG_CMPB      = 2;  // compare_flag_b
  // ==========================================================
  // reset values and count limits
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST   = 8'h00;
  localparam logic [7:0] BOTTOM    = 8'h00;
  localparam logic [7:0] MAX       = 8'hff;
  // ==========================================================
  // modes and output actions
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CLRM   = 3'h2; // clear-on-match mode
  localparam logic [1:0] ACT_NONE    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE  = 2'h1;
  localparam logic [1:0] ACT_CLEAR   = 2'h2;
  localparam logic [1:0] ACT_SET     = 2'h3;
  // read sequencer of the bus slave
  typedef enum logic [1:0] {RD_IDLE, RD_LOAD, RD_DONE} t8c_rd_state_t;
endpackage

// file: core/t8c_reg_if.sv
// t8c_reg_if: register strobe bundle between bus slave and timer core
// assumes: one register access per cycle, byte-wide registers
`timescale 1ns/1ps
interface t8c_reg_if;
  logic       wr_stb; // one-cycle write strobe
  logic [7:0] addr;   // byte offset of the access
  logic [7:0] wdata;  // write data
  logic [7:0] rdata;  // read data of addr
  modport slv  (output wr_stb, addr, wdata, input rdata);
  modport core (input wr_stb, addr, wdata, output rdata);
endinterface

// file: core/t8c_ahb_slv.sv
// t8c_ahb_slv: AHB-Lite slave front end, writes zero-wait, reads one wait
// assumes: single word transfers; hsize is not checked
`timescale 1ns/1ps
module t8c_ahb_slv import t8c_pkg::*; (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  t8c_reg_if.slv           regs
);
  logic          acc;     // address phase taken
  logic          wr_ph_r; // write data phase
  logic [7:0]    addr_r;  // captured offset
  t8c_rd_state_t rd_st_r; // read sequencer
  assign acc = hsel & htrans[1] & hready;
  // ==========================================================
  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r <= 1'b0;
      addr_r  <= 8'h00;
    end else begin
      wr_ph_r <= acc & hwrite;
      if (acc) begin
        addr_r <= haddr[7:0];
      end
    end
  end
  // reads wait one cycle so data always comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_st_r <= RD_IDLE;
    end else begin
      case (rd_st_r)
        RD_LOAD: rd_st_r <= RD_DONE;
        RD_IDLE, RD_DONE: rd_st_r <= (acc & !hwrite) ? RD_LOAD : RD_IDLE;
        default: rd_st_r <= RD_IDLE;
      endcase
    end
  end
  // read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_st_r == RD_LOAD) begin
      hrdata <= {24'h00_0000, regs.rdata};
    end
  end
  assign hreadyout   = (rd_st_r != RD_LOAD);
  assign hresp       = 1'b0;
  assign regs.wr_stb = wr_ph_r;
  assign regs.addr   = addr_r;
  assign regs.wdata  = hwdata[7:0];
endmodule // t8c_ahb_slv

// file: core/t8c_cmp_chan.sv
// t8c_cmp_chan: one compare channel, match detect and output state
// assumes: tick is a one-cycle timer clock enable in the hclk domain
`timescale 1ns/1ps
module t8c_cmp_chan import t8c_pkg::*; (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       tick,
  input  wire logic       blocked,
  input  wire logic       nonpwm,
  input  wire logic [7:0] count,
  input  wire logic [7:0] compare,
  input  wire logic [1:0] action,
  input  wire logic       force_stb,
  output logic            match,
  output logic            state_r
);
  logic hit; // real or forced match that acts on the state
  assign match = tick & !blocked & (count == compare); // see [RULE_01]
  assign hit   = nonpwm & (match | force_stb);         // see [RULE_12]
  // ==========================================================
  // output state, action read live; only a hit moves it, see [RULE_04]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= 1'b0; // see [RULE_06]
    end else if (hit) begin
      case (action) // see [RULE_11] see [RULE_13]
        ACT_TOGGLE: state_r <= !state_r; // see [RULE_20]
        ACT_CLEAR:  state_r <= 1'b0;
        ACT_SET:    state_r <= 1'b1;
        default:    state_r <= state_r;  // see [RULE_10]
      endcase
    end
  end
  // ==========================================================
  // checks
  property p_zero_act;
    @(posedge hclk) disable iff (!hresetn)
      (hit && action == ACT_NONE) |=> $stable(state_r);
  endproperty
  a_zero_act: assert property (p_zero_act) // see [RULE_10]
    else $error("state moved with no action");
  property p_toggle;
    @(posedge hclk) disable iff (!hresetn)
      (hit && action == ACT_TOGGLE) |=> (state_r != $past(state_r));
  endproperty
  a_toggle: assert property (p_toggle) // see [RULE_20]
    else $error("toggle action did not toggle");
endmodule // t8c_cmp_chan

// file: dv/t8c_port_model.sv
// t8c_port_model: pad model of the two timer compare pins
// assumes: each pad has a weak pull-up that wins when nobody drives it
`timescale 1ns/1ps
module t8c_port_model (
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  output logic [1:0]      pad
);
  // ==========================================================
  // pad level
  // an undriven pad goes to the pull-up, never the last driven value
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pad[i] = pin_oe[i] ? pin_out[i] : 1'b1;
    end
  end
endmodule // t8c_port_model

// file: dv/tb_timer8_compare_output_normal_ctc.sv
// tb_timer8_compare_output_normal_ctc: self-checking bench of t8c_timer
// assumes: this bench is the only AHB-Lite master and makes the tick pulses
`timescale 1ns/1ps
module tb_timer8_compare_output_normal_ctc import t8c_pkg::*;;
  // ==========================================================
  // stimulus and observed signals
  logic        hclk = 1'b0;      // 200 MHz bus clock
  logic        hresetn = 1'b0;   // held low from time zero
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        tick = 1'b0;      // one-cycle timer clock enable
  logic        ovf_ack = 1'b0;
  logic        cmpa_ack = 1'b0;
  logic        cmpb_ack = 1'b0;
  logic [1:0]  port_out = 2'h0;
  logic [1:0]  port_dir = 2'h0;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  logic [1:0]  pad;
  logic        ovf_q;
  logic        cmpa_q;
  logic        cmpb_q;
  logic [31:0] rd;               // last read data
  int          num_errors = 0;
  int          n_compared = 0;

  always #2.5 hclk = ~hclk;

  // ==========================================================
  // design and pad model
  t8c_timer dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tick(tick), .ovf_ack(ovf_ack), .cmpa_ack(cmpa_ack),
    .cmpb_ack(cmpb_ack), .port_out(port_out), .port_dir(port_dir),
    .pin_out(pin_out), .pin_oe(pin_oe), .overflow_flag(ovf_q),
    .compare_flag_a(cmpa_q), .compare_flag_b(cmpb_q)
  );
  t8c_port_model port_u (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // look at hready mid-cycle, so the value is settled before the edge
  task automatic wait_rdy;
    do @(negedge hclk); while (hreadyout !== 1'b1);
  endtask
  // one single transfer; entered and left just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  // n back-to-back timer clocks
  task automatic tk(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge hclk);
    end
    tick <= 1'b0;
    @(posedge hclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_chk("ctrl", ADDR_CTRL, 32'h0);
    rd_chk("count", ADDR_COUNT, 32'h0);
    rd_chk("flags", ADDR_FLAGS, 32'h0);
    rd_chk("state", ADDR_STATUS, 32'h0);
    rd_chk("unmapped", 8'h1c, 32'h0);
    port_out <= 2'h2;
    @(posedge hclk);
    chk("pin", {30'h0, pin_out}, 32'h2);
  endtask
  task automatic t_wrap;
    wr(ADDR_COUNT, 32'hfe);
    tk(1);
    rd_chk("count", ADDR_COUNT, 32'hff);
    tk(1);
    rd_chk("count", ADDR_COUNT, 32'h0);
    rd_chk("flags", ADDR_FLAGS, 32'h1 << FLG_OVF);
    chk("ovf flag", {31'h0, ovf_q}, 32'h1);
    ovf_ack <= 1'b1;
    @(posedge hclk);
    ovf_ack <= 1'b0;
    @(posedge hclk);
    rd_chk("flags", ADDR_FLAGS, 32'h0);
    chk("ovf flag", {31'h0, ovf_q}, 32'h0);
  endtask
  // a counter write equal to the compare value loses that match
  task automatic t_block;
    wr(ADDR_CMPA, 32'h5);
    wr(ADDR_COUNT, 32'h5);
    tk(1);
    rd_chk("flags", ADDR_FLAGS, 32'h0);
    rd_chk("count", ADDR_COUNT, 32'h6);
    wr(ADDR_COUNT, 32'h4);
    tk(2);
    rd_chk("flags", ADDR_FLAGS, 32'h1 << FLG_CMPA);
    chk("flag a", {31'h0, cmpa_q}, 32'h1);
    wr(ADDR_FLAGS, 32'h1 << FLG_CMPA);
    rd_chk("flags", ADDR_FLAGS, 32'h0);
    chk("flag a", {31'h0, cmpa_q}, 32'h0);
  endtask
  task automatic t_clr_match;
    wr(ADDR_CMPA, 32'h3);
    wr(ADDR_CTRL, {24'h0, ACT_NONE, ACT_TOGGLE, 1'b0, MODE_CLRM});
    wr(ADDR_COUNT, 32'h0);
    tk(4);
    rd_chk("count", ADDR_COUNT, 32'h0);
    rd_chk("flags", ADDR_FLAGS, 32'h1 << FLG_CMPA);
    rd_chk("state", ADDR_STATUS, 32'h1);
    // state is ready before the pin turns to output
    port_dir <= 2'h1;
    @(posedge hclk);
    chk("pin", {31'h0, pin_out[0]}, 32'h1);
    chk("oe", {30'h0, pin_oe}, 32'h1);
    chk("pad", {30'h0, pad}, 32'h3);
    cmpa_ack <= 1'b1;
    @(posedge hclk);
    cmpa_ack <= 1'b0;
    @(posedge hclk);
    rd_chk("flags", ADDR_FLAGS, 32'h0);
    // top below the count: runs through the wrap, no match on the way
    wr(ADDR_COUNT, 32'h5);
    tk(251);
    rd_chk("count", ADDR_COUNT, 32'h0);
    rd_chk("flags", ADDR_FLAGS, 32'h1 << FLG_OVF);
    wr(ADDR_FLAGS, 32'h7);
    wr(ADDR_CTRL, {24'h0, ACT_NONE, ACT_TOGGLE, 1'b0, MODE_NORMAL});
    rd_chk("state", ADDR_STATUS, 32'h1);
  endtask
  // every action through the force strobe, state starting at one
  task automatic t_force;
    logic [1:0] acts [5] = '{ACT_SET, ACT_TOGGLE, ACT_TOGGLE, ACT_NONE, ACT_CLEAR};
    logic       exp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CTRL, {24'h0, ACT_NONE, acts[i], 1'b0, MODE_NORMAL});
      wr(ADDR_FORCE, 32'h1);
      rd_chk("state", ADDR_STATUS, {31'h0, exp[i]});
      chk("pin", {31'h0, pin_out[0]},
          {31'h0, acts[i] == ACT_NONE ? port_out[0] : exp[i]});
    end
    // odd modes are pwm: the strobe must leave the state alone
    wr(ADDR_CTRL, {24'h0, ACT_NONE, ACT_SET, 1'b0, 3'h1});
    wr(ADDR_FORCE, 32'h1);
    rd_chk("state", ADDR_STATUS, 32'h0);
    rd_chk("flags", ADDR_FLAGS, 32'h0);
    rd_chk("count", ADDR_COUNT, 32'h0);
  endtask
  // channel B: its match sets flag and state, its service pulse clears
  task automatic t_chan_b;
    wr(ADDR_CMPB, 32'h2);
    wr(ADDR_CTRL, {24'h0, ACT_SET, ACT_NONE, 1'b0, MODE_NORMAL});
    wr(ADDR_COUNT, 32'h1);
    tk(2);
    chk("flag b", {31'h0, cmpb_q}, 32'h1);
    rd_chk("state", ADDR_STATUS, 32'h2);
    chk("pin", {30'h0, pin_out}, 32'h2);
    cmpb_ack <= 1'b1;
    @(posedge hclk);
    cmpb_ack <= 1'b0;
    @(posedge hclk);
    chk("flag b", {31'h0, cmpb_q}, 32'h0);
  endtask

  // ==========================================================
  // verdict, main sequence and watchdog
  task automatic wrap_up;
    $display("compares %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_wrap;
    t_block;
    t_clr_match;
    t_force;
    t_chan_b;
    wrap_up;
  end
  // the run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    wrap_up;
  end
endmodule // tb_timer8_compare_output_normal_ctc
